// >>> rtl/ccs_pkg.sv
// Constants, field layouts and carrier types for the custom charger stimulus block.
// Assumes a single 40 MHz clock; this package depends on no other unit.
package ccs_pkg;

	// Register offsets on the management port
	localparam logic [7:0] OFS_S1_RESP = 8'h42;
	localparam logic [7:0] OFS_S1_THPD = 8'h43;
	localparam logic [7:0] OFS_S1_RATIO = 8'h44;
	localparam logic [7:0] OFS_S2_TRIG = 8'h45;
	localparam logic [7:0] OFS_S2_RESP = 8'h46;

	// Field positions and values after reset
	localparam int MAG_LSB = 4;
	localparam int PUPD_LSB = 4;
	localparam int KIND_BIT = 6;
	localparam int DELAY_LSB = 3;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Response select codes
	localparam logic [3:0] SEL_REMOVE = 4'h0;
	localparam logic [3:0] SEL_V_P = 4'h1;
	localparam logic [3:0] SEL_V_M = 4'h2;
	localparam logic [3:0] SEL_V_PM = 4'h3;
	localparam logic [3:0] SEL_R_P = 4'h4;
	localparam logic [3:0] SEL_RSV_A = 4'h5;
	localparam logic [3:0] SEL_D_P = 4'h6;
	localparam logic [3:0] SEL_R_M = 4'h7;
	localparam logic [3:0] SEL_RSV_B = 4'h8;
	localparam logic [3:0] SEL_D_M = 4'h9;
	localparam logic [3:0] SEL_SHORT = 4'hA;
	localparam logic [3:0] SEL_RSV_C = 4'hB;
	localparam logic [3:0] SEL_D_PM = 4'hC;
	localparam logic [3:0] SEL_R_PM = 4'hD;
	localparam logic [3:0] SEL_PD_A = 4'hE;
	localparam logic [3:0] SEL_PD_B = 4'hF;

	// Reserved field codes and the pull-down magnitude
	localparam logic [3:0] MAG_RSV = 4'hF;
	localparam logic [3:0] MAG_PULLDOWN = 4'h0;
	localparam logic [3:0] TH_RSV = 4'hF;
	localparam logic [2:0] RATIO_RSV = 3'h7;

	// Trigger select codes
	localparam logic [2:0] TRIG_VBUS_PRE = 3'h0;
	localparam logic [2:0] TRIG_DP_GT = 3'h1;
	localparam logic [2:0] TRIG_WINDOW = 3'h2;
	localparam logic [2:0] TRIG_DM_GT = 3'h3;
	localparam logic [2:0] TRIG_RSV_A = 3'h4;
	localparam logic [2:0] TRIG_RSV_B = 3'h5;
	localparam logic [2:0] TRIG_DP_GT_ALT = 3'h6;
	localparam logic [2:0] TRIG_VBUS_ON = 3'h7;

	// Millisecond base of the stimulus timer
	localparam int MS_TIME_NS = 1000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {LN_NONE = 2'h0, LN_VOLT = 2'h1, LN_RES = 2'h2, LN_DIV = 2'h3} ccs_line_kind_e;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_DETECT = 5'b00010,
		ST_DELAY = 5'b00100,
		ST_HOLD = 5'b01000,
		ST_DONE = 5'b10000
	} ccs_stage_e;

	typedef struct packed {ccs_line_kind_e kind; logic [3:0] mag; logic pd15k;} ccs_line_s;
	typedef struct packed {logic vbus_pre; logic vbus_on; logic dp_gt; logic dp_lt; logic dp_floor; logic dm_gt;} ccs_sense_s;
	typedef struct packed {logic [3:0] mag; logic [3:0] sel;} ccs_resp_s;
	typedef struct packed {logic kind; logic [2:0] delay; logic [2:0] sel;} ccs_trig_s;

	function automatic logic sel_reserved(input logic [3:0] s);
		sel_reserved = (s == SEL_RSV_A) || (s == SEL_RSV_B) || (s == SEL_RSV_C);
	endfunction : sel_reserved

	function automatic logic [6:0] delay_ms(input logic [2:0] c);
		case (c)
			3'h0: delay_ms = 7'h00;
			3'h1: delay_ms = 7'h01;
			3'h2: delay_ms = 7'h05;
			3'h3: delay_ms = 7'h0A;
			3'h4: delay_ms = 7'h14;
			3'h5: delay_ms = 7'h28;
			3'h6: delay_ms = 7'h50;
			default: delay_ms = 7'h64;
		endcase
	endfunction : delay_ms

endpackage : ccs_pkg

// >>> rtl/ccs_ms_tick.sv
// Millisecond base: one-cycle enable pulse every CYCLES clocks.
// Assumes CYCLES of at least 2; counting restarts while run is low.
`timescale 1ns/1ps
`default_nettype none
module ccs_ms_tick #(
	parameter int unsigned CYCLES = 40000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(CYCLES);
	logic [W-1:0] cnt_q;

	// Free count while running, pulse on wrap
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= '0;
			tick <= 1'b0;
		end
		else if (!run)
		begin
			cnt_q <= '0;
			tick <= 1'b0;
		end
		else if (cnt_q == W'(CYCLES - 1))
		begin
			cnt_q <= '0;
			tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : ccs_ms_tick
`default_nettype wire

// >>> rtl/ccs_stage.sv
// One stimulus stage: trigger detect, delay or hold timer, apply level.
// Assumes comparator results in sense are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ccs_stage (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire ccs_pkg::ccs_trig_s trig,
	input wire ccs_pkg::ccs_sense_s sense,
	input wire logic ms_tick,
	output logic apply,
	output logic done
);
	ccs_pkg::ccs_stage_e state_q;
	logic [6:0] cnt_q;
	logic hit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Trigger decode; reserved codes never fire
	always_comb
	begin
		case (trig.sel)
			ccs_pkg::TRIG_VBUS_PRE: hit = sense.vbus_pre;
			ccs_pkg::TRIG_VBUS_ON: hit = sense.vbus_on;
			ccs_pkg::TRIG_DP_GT, ccs_pkg::TRIG_DP_GT_ALT: hit = sense.dp_gt;
			ccs_pkg::TRIG_DM_GT: hit = sense.dm_gt;
			ccs_pkg::TRIG_WINDOW: hit = sense.dp_lt && sense.dp_floor;
			default: hit = 1'b0;
		endcase
	end

	// Stage sequence
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ccs_pkg::ST_IDLE;
			cnt_q <= 7'h00;
			apply <= 1'b0;
		end
		else if (!run)
		begin
			state_q <= ccs_pkg::ST_IDLE;
			cnt_q <= 7'h00;
			apply <= 1'b0;
		end
		else
		begin
			case (state_q)
				ccs_pkg::ST_IDLE:
				begin
					cnt_q <= ccs_pkg::delay_ms(trig.delay);
					state_q <= ccs_pkg::ST_DETECT;
				end
				ccs_pkg::ST_DETECT:
				begin
					if (hit && trig.kind)
					begin
						apply <= 1'b1;
						state_q <= ccs_pkg::ST_HOLD;
					end
					else if (hit)
						state_q <= ccs_pkg::ST_DELAY;
				end
				ccs_pkg::ST_DELAY:
				begin
					if (cnt_q == 7'h00)
					begin
						apply <= 1'b1;
						state_q <= ccs_pkg::ST_DONE;
					end
					else if (ms_tick)
						cnt_q <= cnt_q - 7'h01;
				end
				ccs_pkg::ST_HOLD:
				begin
					if (cnt_q == 7'h00)
					begin
						apply <= hit;
						state_q <= ccs_pkg::ST_DONE;
					end
					else if (ms_tick)
						cnt_q <= cnt_q - 7'h01;
				end
				ccs_pkg::ST_DONE:
				begin
					if (trig.kind && !hit)
						apply <= 1'b0;
				end
				default: state_q <= ccs_pkg::ST_IDLE;
			endcase
		end
	end

	// Next stage may start whatever the stimulus does afterwards
	assign done = (state_q == ccs_pkg::ST_DONE);

	chk_hold_now: assert property (run && state_q == ccs_pkg::ST_DETECT && hit && trig.kind |=> apply)
		else $error("response not applied at detection");
	chk_delay_first: assert property (run && state_q == ccs_pkg::ST_DETECT && hit && !trig.kind
		&& cnt_q != 7'h00 |=> !apply)
		else $error("response applied before delay");
endmodule : ccs_stage
`default_nettype wire

// >>> rtl/ccs_top.sv
// Custom charger stimulus stages 1 and 2: registers, sequencing, data-line response state.
// Assumes a management port engine outside delivers single-cycle register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module ccs_top #(
	parameter int unsigned MS_CYCLES = ccs_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic emul_run,
	input wire logic legacy_active,
	input wire logic standard_active,
	input wire ccs_pkg::ccs_trig_s stage1_trigger,
	input wire logic [1:0] stage2_pulldown_current,
	input wire logic [2:0] stage2_divider_tap,
	input wire ccs_pkg::ccs_sense_s stage1_sense,
	input wire ccs_pkg::ccs_sense_s stage2_sense,
	output ccs_pkg::ccs_line_s positive_data_output,
	output ccs_pkg::ccs_line_s negative_data_output,
	output logic data_short_en,
	output logic pulldown_current_en,
	output logic [1:0] pulldown_current_code,
	output logic [2:0] divider_tap,
	output logic [3:0] stage1_compare_level,
	output logic stage1_compare_en,
	output logic stage2_compare_en,
	output logic stage1_applied,
	output logic stage2_applied
);
	ccs_pkg::ccs_resp_s s1_resp_q;
	ccs_pkg::ccs_resp_s s2_resp_q;
	ccs_pkg::ccs_trig_s s2_trig_q;
	logic [1:0] s1_pupd_q;
	logic [3:0] s1_th_q;
	logic [2:0] s1_ratio_q;
	logic s1_done, s2_done, ms_tick;
	logic s1_apply, s2_apply, s1_prev_q, s2_prev_q;
	logic s1_on, s1_off, s2_on, s2_off;
	logic [7:0] wr_resp;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Line response update for one event on one data line
	function automatic ccs_pkg::ccs_line_s line_upd(input ccs_pkg::ccs_line_s cur, input logic [3:0] sel,
		input logic [3:0] mag, input logic [2:0] stim, input logic is_dp);
		ccs_pkg::ccs_line_s nxt;
		logic hv;
		logic hr;
		logic hd;
		nxt = cur;
		hv = (sel == ccs_pkg::SEL_V_PM) || (sel == (is_dp ? ccs_pkg::SEL_V_P : ccs_pkg::SEL_V_M));
		hr = (sel == ccs_pkg::SEL_R_PM) || (sel == (is_dp ? ccs_pkg::SEL_R_P : ccs_pkg::SEL_R_M));
		hd = (sel == ccs_pkg::SEL_D_PM) || (sel == (is_dp ? ccs_pkg::SEL_D_P : ccs_pkg::SEL_D_M));
		if (sel == ccs_pkg::SEL_REMOVE)
			nxt.kind = ccs_pkg::LN_NONE;
		else if (sel == ccs_pkg::SEL_PD_A || sel == ccs_pkg::SEL_PD_B)
		begin
			if (stim == ccs_pkg::TRIG_VBUS_ON)
				nxt.pd15k = 1'b0;
		end
		else if (hv || hr || hd)
		begin
			nxt.kind = hv ? ccs_pkg::LN_VOLT : (hr ? ccs_pkg::LN_RES : ccs_pkg::LN_DIV);
			nxt.mag = mag;
			nxt.pd15k = 1'b0;
		end
		else if (stim != ccs_pkg::TRIG_VBUS_PRE && cur.kind == ccs_pkg::LN_NONE)
			nxt.pd15k = 1'b0;
		line_upd = nxt;
	endfunction : line_upd

	// Millisecond base for both stage timers
	ccs_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.clk(clk),
		.rstn(rstn),
		.run(emul_run),
		.tick(ms_tick)
	);

	// Stage one runs from emulation start
	ccs_stage u_stage1 (
		.clk(clk),
		.rstn(rstn),
		.run(emul_run),
		.trig(stage1_trigger),
		.sense(stage1_sense),
		.ms_tick(ms_tick),
		.apply(s1_apply),
		.done(s1_done)
	);

	// Stage two waits for stage one to finish
	ccs_stage u_stage2 (
		.clk(clk),
		.rstn(rstn),
		.run(emul_run && s1_done),
		.trig(s2_trig_q),
		.sense(stage2_sense),
		.ms_tick(ms_tick),
		.apply(s2_apply),
		.done(s2_done)
	);

	// Response register writes, reserved fields keep their value
	always_comb
	begin
		wr_resp = reg_wdata;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_resp_q <= ccs_pkg::REG_RESET;
			s2_resp_q <= ccs_pkg::REG_RESET;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ccs_pkg::OFS_S1_RESP && wr_resp[7:4] != ccs_pkg::MAG_RSV)
				s1_resp_q.mag <= wr_resp[ccs_pkg::MAG_LSB +: 4];
			if (reg_addr == ccs_pkg::OFS_S1_RESP && !ccs_pkg::sel_reserved(wr_resp[3:0]))
				s1_resp_q.sel <= wr_resp[3:0];
			if (reg_addr == ccs_pkg::OFS_S2_RESP && wr_resp[7:4] != ccs_pkg::MAG_RSV)
				s2_resp_q.mag <= wr_resp[ccs_pkg::MAG_LSB +: 4];
			if (reg_addr == ccs_pkg::OFS_S2_RESP && !ccs_pkg::sel_reserved(wr_resp[3:0]))
				s2_resp_q.sel <= wr_resp[3:0];
		end
	end

	// Threshold, pull-down current, ratio and stage two trigger writes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_pupd_q <= 2'h0;
			s1_th_q <= 4'h0;
			s1_ratio_q <= 3'h0;
			s2_trig_q <= 7'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ccs_pkg::OFS_S1_THPD)
				s1_pupd_q <= reg_wdata[ccs_pkg::PUPD_LSB +: 2];
			if (reg_addr == ccs_pkg::OFS_S1_THPD && reg_wdata[3:0] != ccs_pkg::TH_RSV)
				s1_th_q <= reg_wdata[3:0];
			if (reg_addr == ccs_pkg::OFS_S1_RATIO && reg_wdata[2:0] != ccs_pkg::RATIO_RSV)
				s1_ratio_q <= reg_wdata[2:0];
			if (reg_addr == ccs_pkg::OFS_S2_TRIG)
			begin
				s2_trig_q.kind <= reg_wdata[ccs_pkg::KIND_BIT];
				s2_trig_q.delay <= reg_wdata[ccs_pkg::DELAY_LSB +: 3];
				if (reg_wdata[2:0] != ccs_pkg::TRIG_RSV_A && reg_wdata[2:0] != ccs_pkg::TRIG_RSV_B)
					s2_trig_q.sel <= reg_wdata[2:0];
			end
		end
	end

	// Registered read data; unmapped and unimplemented bits read zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				ccs_pkg::OFS_S1_RESP: reg_rdata <= s1_resp_q;
				ccs_pkg::OFS_S1_THPD: reg_rdata <= {2'h0, s1_pupd_q, s1_th_q};
				ccs_pkg::OFS_S1_RATIO: reg_rdata <= {5'h00, s1_ratio_q};
				ccs_pkg::OFS_S2_TRIG: reg_rdata <= {1'b0, s2_trig_q};
				ccs_pkg::OFS_S2_RESP: reg_rdata <= s2_resp_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Profile-gated copies seen by the analog side
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			stage1_compare_level <= 4'h0;
		else if (!legacy_active)
			stage1_compare_level <= s1_th_q;
	end

	// Threshold only matters for data line triggers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1_compare_en <= 1'b0;
			stage2_compare_en <= 1'b0;
		end
		else
		begin
			stage1_compare_en <= stage1_trigger.sel != ccs_pkg::TRIG_VBUS_PRE
				&& stage1_trigger.sel != ccs_pkg::TRIG_VBUS_ON;
			stage2_compare_en <= s2_trig_q.sel != ccs_pkg::TRIG_VBUS_PRE
				&& s2_trig_q.sel != ccs_pkg::TRIG_VBUS_ON;
		end
	end

	// Apply edges of each stage
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_prev_q <= 1'b0;
			s2_prev_q <= 1'b0;
		end
		else
		begin
			s1_prev_q <= s1_apply;
			s2_prev_q <= s2_apply;
		end
	end

	assign s1_on = s1_apply && !s1_prev_q;
	assign s1_off = !s1_apply && s1_prev_q && emul_run;
	assign s2_on = s2_apply && !s2_prev_q;
	assign s2_off = !s2_apply && s2_prev_q && emul_run;
	assign stage1_applied = s1_prev_q;
	assign stage2_applied = s2_prev_q;

	// Data line response state; emulation reset leaves the 15k pull-downs on
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			positive_data_output <= {ccs_pkg::LN_NONE, 4'h0, 1'b1};
			negative_data_output <= {ccs_pkg::LN_NONE, 4'h0, 1'b1};
		end
		else if (!emul_run)
		begin
			positive_data_output <= {ccs_pkg::LN_NONE, 4'h0, 1'b1};
			negative_data_output <= {ccs_pkg::LN_NONE, 4'h0, 1'b1};
		end
		else if (s2_on)
		begin
			positive_data_output <= line_upd(positive_data_output, s2_resp_q.sel, s2_resp_q.mag, s2_trig_q.sel, 1'b1);
			negative_data_output <= line_upd(negative_data_output, s2_resp_q.sel, s2_resp_q.mag, s2_trig_q.sel, 1'b0);
		end
		else if (s1_on)
		begin
			positive_data_output <= line_upd(positive_data_output, s1_resp_q.sel, s1_resp_q.mag,
				stage1_trigger.sel, 1'b1);
			negative_data_output <= line_upd(negative_data_output, s1_resp_q.sel, s1_resp_q.mag,
				stage1_trigger.sel, 1'b0);
		end
		else if (s1_off || s2_off)
		begin
			positive_data_output.kind <= ccs_pkg::LN_NONE;
			negative_data_output.kind <= ccs_pkg::LN_NONE;
		end
	end

	// Short between the lines, cleared by withdrawal
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			data_short_en <= 1'b0;
		else if (!emul_run || s1_off || s2_off)
			data_short_en <= 1'b0;
		else if ((s2_on && s2_resp_q.sel == ccs_pkg::SEL_SHORT) || (!s2_on && s1_on && s1_resp_q.sel == ccs_pkg::SEL_SHORT))
			data_short_en <= 1'b1;
		else if ((s2_on && s2_resp_q.sel == ccs_pkg::SEL_REMOVE) || (s1_on && s1_resp_q.sel == ccs_pkg::SEL_REMOVE))
			data_short_en <= 1'b0;
	end

	// Current (outside legacy) and ratio (outside standard) settings of the stage that last applied
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pulldown_current_code <= 2'h0;
			divider_tap <= 3'h0;
		end
		else if (s2_on)
		begin
			if (!legacy_active)
				pulldown_current_code <= stage2_pulldown_current;
			if (!standard_active)
				divider_tap <= stage2_divider_tap;
		end
		else if (s1_on)
		begin
			if (!legacy_active)
				pulldown_current_code <= s1_pupd_q;
			if (!standard_active)
				divider_tap <= s1_ratio_q;
		end
	end

	// Pull-down current when either line has a pull-down voltage response
	assign pulldown_current_en = (positive_data_output.kind == ccs_pkg::LN_VOLT
		&& positive_data_output.mag == ccs_pkg::MAG_PULLDOWN)
		|| (negative_data_output.kind == ccs_pkg::LN_VOLT
		&& negative_data_output.mag == ccs_pkg::MAG_PULLDOWN);

	sequence s1_fires(logic [3:0] code);
		emul_run && s1_on && !s2_on && s1_resp_q.sel == code;
	endsequence

	chk_resv_sel: assert property (reg_wr && reg_addr == ccs_pkg::OFS_S1_RESP
		&& ccs_pkg::sel_reserved(reg_wdata[3:0]) |=> $stable(s1_resp_q.sel))
		else $error("reserved response select accepted");
	chk_resv_mag: assert property (reg_wr && reg_addr == ccs_pkg::OFS_S2_RESP
		&& reg_wdata[7:4] == ccs_pkg::MAG_RSV |=> $stable(s2_resp_q.mag))
		else $error("reserved magnitude accepted");
	chk_resv_th: assert property (reg_wr && reg_addr == ccs_pkg::OFS_S1_THPD
		&& reg_wdata[3:0] == ccs_pkg::TH_RSV |=> $stable(s1_th_q))
		else $error("reserved threshold accepted");
	chk_resv_ratio: assert property (reg_wr && reg_addr == ccs_pkg::OFS_S1_RATIO
		&& reg_wdata[2:0] == ccs_pkg::RATIO_RSV |=> $stable(s1_ratio_q))
		else $error("reserved ratio accepted");
	chk_withdraw_both: assert property (s1_fires(ccs_pkg::SEL_REMOVE) |=> positive_data_output.kind == ccs_pkg::LN_NONE
		&& negative_data_output.kind == ccs_pkg::LN_NONE)
		else $error("prior response not withdrawn");
	chk_pd_current: assert property (s1_fires(ccs_pkg::SEL_V_PM) ##0 (s1_resp_q.mag == ccs_pkg::MAG_PULLDOWN)
		|=> pulldown_current_en)
		else $error("pull-down current missing");
	chk_pd_release: assert property (s1_fires(ccs_pkg::SEL_PD_A) ##0 (stage1_trigger.sel == ccs_pkg::TRIG_VBUS_ON)
		|=> !positive_data_output.pd15k && !negative_data_output.pd15k)
		else $error("15k pull-downs not released");
	chk_stage_order: assert property (s2_apply |-> s1_done)
		else $error("stage two ahead of stage one");
	chk_done_order: assert property (s2_done |-> s1_done)
		else $error("stage two finished ahead of stage one");
	chk_legacy_freeze: assert property (legacy_active |=> $stable(stage1_compare_level))
		else $error("compare level refreshed in legacy profile");
	chk_std_freeze: assert property (standard_active |=> $stable(divider_tap))
		else $error("divider tap refreshed in standard profile");
endmodule : ccs_top
`default_nettype wire

// >>> tb/ccs_dev_model.sv
// Portable device model: comparator view of the data lines and bus supply.
// Assumes the bench raises attach to present every stimulus but dp_lt and dm_gt at once.
`timescale 1ns/1ps
`default_nettype none
module ccs_dev_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic attach,
	output ccs_pkg::ccs_sense_s sense
);
	// Level appears one cycle after attach, like a settled comparator
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sense <= '0;
		else
			sense <= '{vbus_pre: attach, vbus_on: attach, dp_gt: attach, dp_lt: 1'b0, dp_floor: attach, dm_gt: 1'b0};
	end
endmodule : ccs_dev_model
`default_nettype wire

// >>> tb/ccs_top_tb.sv
// Self-checking bench for the stimulus register block and its two stages.
// Assumes the device model supplies sense; stage 2 settings are driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module ccs_top_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic emul_run = 1'b0;
	logic legacy_active = 1'b0;
	logic standard_active = 1'b0;
	logic attach = 1'b0;
	logic [1:0] s2_cur = 2'h0;
	logic [2:0] s2_tap = 3'h0;
	ccs_pkg::ccs_trig_s trig1 = '0;
	ccs_pkg::ccs_sense_s sense;
	ccs_pkg::ccs_line_s pos_line;
	ccs_pkg::ccs_line_s neg_line;
	logic pd_en;
	logic s1_cmp_en;
	logic s1_app;
	logic s2_app;
	logic short_en;
	logic [1:0] cur_code;
	logic [2:0] tap;
	logic [3:0] cmp_lvl;
	logic s2_cmp_en;
	logic [7:0] mir [0:15];
	int failures = 0;
	int checks_done = 0;
	int cnt;
	logic [7:0] a;
	logic [7:0] d;
	logic [3:0] sels [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hD, 4'h6, 4'h9, 4'hC};

	// 40 MHz clock
	always #12.5 clk = ~clk;

	ccs_top #(.MS_CYCLES(4)) i_ccs_top (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .emul_run(emul_run),
		.legacy_active(legacy_active), .standard_active(standard_active), .stage1_trigger(trig1),
		.stage2_pulldown_current(s2_cur), .stage2_divider_tap(s2_tap), .stage1_sense(sense),
		.stage2_sense(sense), .positive_data_output(pos_line), .negative_data_output(neg_line),
		.data_short_en(short_en), .pulldown_current_en(pd_en), .pulldown_current_code(cur_code),
		.divider_tap(tap), .stage1_compare_level(cmp_lvl), .stage1_compare_en(s1_cmp_en),
		.stage2_compare_en(s2_cmp_en),
		.stage1_applied(s1_app), .stage2_applied(s2_app));

	ccs_dev_model i_ccs_dev_model (.clk(clk), .rstn(rstn), .attach(attach), .sense(sense));

	// Expected register contents after a write; reserved codes leave a field as it was
	function automatic logic [7:0] nx(input logic [7:0] ad, input logic [7:0] o, input logic [7:0] n);
		logic [7:0] r;
		r = o;
		case (ad)
			8'h42, 8'h46:
			begin
				if (n[3:0] != 4'h5 && n[3:0] != 4'h8 && n[3:0] != 4'hB) r[3:0] = n[3:0];
				if (n[7:4] != 4'hF) r[7:4] = n[7:4];
			end
			8'h43:
			begin
				r[5:4] = n[5:4];
				if (n[3:0] != 4'hF) r[3:0] = n[3:0];
			end
			8'h44: if (n[2:0] != 3'h7) r[2:0] = n[2:0];
			8'h45:
			begin
				r[6:3] = n[6:3];
				if (n[2:1] != 2'b10) r[2:0] = n[2:0];
			end
			default: r = 8'h00;
		endcase
		return r;
	endfunction : nx

	// Line kinds {positive, negative} for a response select code
	function automatic logic [3:0] kinds(input logic [3:0] s);
		case (s)
			4'h1: return 4'b0100;
			4'h2: return 4'b0001;
			4'h3: return 4'b0101;
			4'h4: return 4'b1000;
			4'h7: return 4'b0010;
			4'hD: return 4'b1010;
			4'h6: return 4'b1100;
			4'h9: return 4'b0011;
			4'hC: return 4'b1111;
			default: return 4'b0000;
		endcase
	endfunction : kinds

	task automatic wr(input logic [7:0] ad, input logic [7:0] v);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = ad;
		reg_wdata = v;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		mir[ad[3:0]] = (ad[7:4] == 4'h4) ? nx(ad, mir[ad[3:0]], v) : mir[ad[3:0]];
	endtask : wr

	task automatic rd_chk(input logic [7:0] ad);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = ad;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		`CHK(reg_rdata, (ad[7:4] == 4'h4) ? mir[ad[3:0]] : 8'h00)
	endtask : rd_chk

	// Restart emulation, present the stimulus and wait for the stage 1 response
	task automatic run_s1();
		@(posedge clk);
		#1 emul_run = 1'b0;
		attach = 1'b0;
		repeat (3) @(posedge clk);
		#1 emul_run = 1'b1;
		attach = 1'b1;
		cnt = 0;
		while (s1_app !== 1'b1 && cnt < 200)
		begin
			@(posedge clk);
			#1 cnt++;
		end
	endtask : run_s1

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// Watchdog well beyond the expected run length
	initial
	begin
		#(25 * 40000);
		failures++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h781a));
		foreach (mir[i]) mir[i] = 8'h00;
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		for (int i = 8'h40; i < 8'h48; i++) rd_chk(i[7:0]);
		$display("Test reset values done");
		for (int i = 0; i < 60; i++)
		begin
			a = 8'h41 + 8'($urandom % 7);
			d = 8'($urandom);
			legacy_active = 1'($urandom);
			s2_cur = 2'($urandom);
			s2_tap = 3'($urandom);
			wr(a, d);
			rd_chk(a);
			if (!legacy_active) `CHK(cmp_lvl, mir[3][3:0])
		end
		legacy_active = 1'b0;
		$display("Test random register access done");
		// Stage 2 waits on a negative line level that never comes
		wr(8'h45, 8'h03);
		trig1 = 7'b0_000_001;
		foreach (sels[i])
		begin
			wr(8'h42, {4'h2, sels[i]});
			run_s1();
			`CHK({pos_line.kind, neg_line.kind}, kinds(sels[i]))
			`CHK(pos_line.mag | neg_line.mag, (sels[i] == 4'h0) ? 4'h0 : 4'h2)
			`CHK(s2_app, 1'b0)
		end
		$display("Test response codes done");
		wr(8'h42, 8'h03);
		run_s1();
		@(posedge clk);
		#1 `CHK(pd_en, 1'b1)
		`CHK(s1_cmp_en, 1'b1)
		`CHK(cur_code, mir[3][5:4])
		`CHK(tap, mir[4][2:0])
		trig1 = 7'b0_000_000;
		repeat (3) @(posedge clk);
		#1 `CHK(s1_cmp_en, 1'b0)
		$display("Test pull-down current and compare enable done");
		trig1 = 7'b0_010_001;
		run_s1();
		`CHK((cnt >= 15 && cnt <= 27), 1'b1)
		$display("Test delay timer done");
		// Bus supply triggers keep or drop the emulation-reset pull-downs
		wr(8'h42, 8'h21);
		trig1 = 7'b0_000_000;
		run_s1();
		`CHK({pos_line.pd15k, neg_line.pd15k}, 2'b01)
		wr(8'h42, 8'h0E);
		run_s1();
		`CHK({pos_line.pd15k, neg_line.pd15k}, 2'b11)
		trig1 = 7'b0_000_111;
		run_s1();
		`CHK({pos_line.pd15k, neg_line.pd15k}, 2'b00)
		$display("Test pull-down release done");
		// Hold timer: applied at once, removed after the hold once the stimulus is gone
		wr(8'h42, 8'h21);
		trig1 = 7'b1_001_110;
		run_s1();
		`CHK((cnt <= 3), 1'b1)
		`CHK({pos_line.kind, neg_line.kind}, 4'b0100)
		attach = 1'b0;
		repeat (12) @(posedge clk);
		#1 `CHK({pos_line.kind, neg_line.kind}, 4'b0000)
		$display("Test hold timer done");
		// Stage two withdraws a voltage, then a short; tap frozen by the standard profile
		wr(8'h45, 8'h01);
		wr(8'h46, 8'h00);
		trig1 = 7'b0_000_001;
		s2_cur = ~mir[3][5:4];
		s2_tap = ~mir[4][2:0];
		for (int k = 0; k < 2; k++)
		begin
			d = k ? 8'h0A : 8'h03;
			wr(8'h42, d);
			run_s1();
			standard_active = 1'b1;
			`CHK(s2_app, 1'b0)
			`CHK(short_en, (k == 1))
			cnt = 0;
			while (s2_app !== 1'b1 && cnt < 100)
			begin
				@(posedge clk);
				#1 cnt++;
			end
			`CHK({pos_line.kind, neg_line.kind}, 4'b0000)
			`CHK(short_en, 1'b0)
			`CHK(tap, mir[4][2:0])
			`CHK(cur_code, s2_cur)
			standard_active = 1'b0;
		end
		`CHK(s2_cmp_en, 1'b1)
		wr(8'h45, 8'h07);
		@(posedge clk);
		#1 `CHK(s2_cmp_en, 1'b0)
		$display("Test stage two withdrawal done");
		wrap_up();
	end
endmodule : ccs_top_tb
`default_nettype wire
